// File: hw/drsr_ctrl.sv
// Memory controller end: refresh scheduling, self-refresh entry and exit, link clock.
`timescale 1ns/100ps
`include "drsr_cfg.svh"
module drsr_ctrl (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   drsr_if.ctrl link,
   input wire logic cmd_valid_i,
   input wire drsr_pkg::drsr_ucmd_t cmd_i,
   input wire logic [13:0] cmd_addr_i,
   input wire logic [2:0] cmd_bank_i,
   output logic cmd_ready_o,
   input wire logic odt_i,
   input wire logic sr_req_i,
   output logic sr_active_o,
   output logic ref_issued_o,
   output logic signed [4:0] ref_debt_o
);
   import drsr_pkg::*;
   localparam drsr_cnt_t REFI_C = drsr_cnt_t'(`DRSR_REFI_CYC - 1);
   localparam drsr_cnt_t RFC_C = drsr_cnt_t'(`DRSR_RFC_CYC);
   localparam drsr_cnt_t RP_C = drsr_cnt_t'(`DRSR_RP_CYC);
   localparam drsr_cnt_t XS_C = drsr_cnt_t'(`DRSR_XS_CYC);
   localparam drsr_cnt_t SRMIN_C = drsr_cnt_t'(`DRSR_SR_MIN_CYC);
   localparam drsr_cnt_t CKSRX_C = drsr_cnt_t'(`DRSR_CKSRX_CYC);
   localparam drsr_cnt_t XSDLL_C = drsr_cnt_t'(`DRSR_XSDLL_CYC);
   localparam drsr_cnt_t TERMINATION_LATENCY_C = drsr_cnt_t'(`DRSR_TERMINATION_LATENCY_CYC);

   drsr_cst_t st_q;
   drsr_cst_t st_d;
   logic ck_q;
   logic ck_run_q;
   logic ck_run_d;
   logic signed [4:0] debt_q;
   logic signed [4:0] debt_d;
   logic [3:0] gap_q;
   logic open_q;
   logic open_d;
   logic owe_q;
   logic owe_d;
   logic cke_q;
   logic cke_d;
   logic cs_n_q;
   logic cs_n_d;
   logic [2:0] rcw_q;
   logic [2:0] rcw_d;
   logic [13:0] addr_q;
   logic [13:0] addr_d;
   logic [2:0] ba_q;
   logic [2:0] ba_d;
   logic odt_q;
   logic rst_n_q;
   logic ref_now;
   logic ref_iss_q;
   logic w_load;
   drsr_cnt_t w_cnt;
   logic w_done;
   logic d_load;
   logic d_done;
   logic tick;

   // Commands change while the link clock is low and are taken at its next rising edge.
   logic slot;
   logic in_sr;
   logic force_ref;
   logic sr_ref;
   logic pull_ref;
   logic go_sr;
   logic svc;
   logic dll_cmd;
   logic user_go;
   logic [2:0] user_enc;

   assign slot = ck_q && ck_run_q;
   assign in_sr = (st_q == DRSR_ST_SR_MIN) || (st_q == DRSR_ST_SR) || (st_q == DRSR_ST_CKON);
   // Pulled-in credit must not stretch the gap between two refreshes past the postpone limit.
   assign force_ref = (debt_q >= `DRSR_DEBT_MAX) || (gap_q >= `DRSR_GAP_MAX);
   assign sr_ref = sr_req_i && ((debt_q > 5'sh00) || owe_q);
   assign pull_ref = !cmd_valid_i && !sr_req_i && (debt_q > `DRSR_DEBT_MIN);
   assign go_sr = sr_req_i && (debt_q <= 5'sh00) && !owe_q;
   assign svc = force_ref || sr_ref || go_sr || pull_ref;
   assign dll_cmd = (cmd_i == DRSR_U_RD) || (cmd_i == DRSR_U_WR);
   assign cmd_ready_o = (st_q == DRSR_ST_RUN) && slot && cke_q && !svc
                        && (!dll_cmd || d_done);
   assign user_go = cmd_valid_i && cmd_ready_o;
   assign user_enc = (cmd_i == DRSR_U_ACT) ? `DRSR_ENC_ACT :
                     (cmd_i == DRSR_U_RD) ? `DRSR_ENC_RD :
                     (cmd_i == DRSR_U_WR) ? `DRSR_ENC_WR : `DRSR_ENC_PRE;

   always_comb
   begin
      st_d = st_q;
      ck_run_d = ck_run_q;
      open_d = open_q;
      owe_d = owe_q;
      // Clock enable comes up at the first slot after the link leaves reset.
      cke_d = cke_q || (slot && (st_q == DRSR_ST_RUN));
      cs_n_d = cs_n_q;
      rcw_d = rcw_q;
      addr_d = addr_q;
      ba_d = ba_q;
      w_load = 1'b0;
      w_cnt = '0;
      d_load = 1'b0;
      ref_now = 1'b0;
      if (slot)
      begin
         cs_n_d = 1'b0;
         rcw_d = `DRSR_ENC_NOP;
      end
      unique case (st_q)
         DRSR_ST_RUN:
            if (slot && svc && cke_q)
            begin
               if (open_q)
               begin
                  rcw_d = `DRSR_ENC_PRE;
                  addr_d[`DRSR_A10_ALL] = 1'b1;
                  open_d = 1'b0;
                  st_d = DRSR_ST_PRE;
                  w_load = 1'b1;
                  w_cnt = RP_C;
               end
               else if (go_sr && !force_ref)
               begin
                  st_d = DRSR_ST_ODT;
                  w_load = 1'b1;
                  w_cnt = TERMINATION_LATENCY_C;
               end
               else
               begin
                  rcw_d = `DRSR_ENC_REF;
                  ref_now = 1'b1;
                  owe_d = 1'b0;
                  st_d = DRSR_ST_REF;
                  w_load = 1'b1;
                  w_cnt = RFC_C;
               end
            end
            else if (user_go)
            begin
               rcw_d = user_enc;
               addr_d = cmd_addr_i;
               ba_d = cmd_bank_i;
               open_d = (cmd_i == DRSR_U_ACT) || (open_q && (cmd_i != DRSR_U_PRE));
            end
         DRSR_ST_PRE, DRSR_ST_REF, DRSR_ST_XS:
            if (w_done)
               st_d = DRSR_ST_RUN;
         DRSR_ST_ODT:
            if (w_done && slot)
            begin
               cke_d = 1'b0;
               rcw_d = `DRSR_ENC_REF;
               st_d = DRSR_ST_SR_MIN;
               w_load = 1'b1;
               w_cnt = SRMIN_C;
            end
         DRSR_ST_SR_MIN:
            if (w_done && ck_q)
            begin
               ck_run_d = 1'b0;
               st_d = DRSR_ST_SR;
            end
         DRSR_ST_SR:
            if (!sr_req_i)
            begin
               ck_run_d = 1'b1;
               st_d = DRSR_ST_CKON;
               w_load = 1'b1;
               w_cnt = CKSRX_C;
            end
         DRSR_ST_CKON:
            if (w_done && slot)
            begin
               cke_d = 1'b1;
               owe_d = 1'b1;
               d_load = 1'b1;
               st_d = DRSR_ST_XS;
               w_load = 1'b1;
               w_cnt = XS_C;
            end
      endcase
      debt_d = debt_q + ((tick && !in_sr) ? 5'sh01 : 5'sh00)
               - ((ref_now && (debt_q > `DRSR_DEBT_MIN)) ? 5'sh01 : 5'sh00);
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         st_q <= DRSR_ST_RUN;
         ck_q <= 1'b0;
         ck_run_q <= 1'b1;
         debt_q <= 5'sh00;
         gap_q <= 4'h0;
         open_q <= 1'b0;
         owe_q <= 1'b0;
         cke_q <= 1'b0;
         cs_n_q <= 1'b1;
         rcw_q <= `DRSR_ENC_NOP;
         addr_q <= 14'h0000;
         ba_q <= 3'h0;
         odt_q <= 1'b0;
         rst_n_q <= 1'b0;
         ref_iss_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         ck_q <= ck_run_q && !ck_q;
         ck_run_q <= ck_run_d;
         debt_q <= debt_d;
         if (ref_now || in_sr)
            gap_q <= 4'h0;
         else if (tick && (gap_q != `DRSR_GAP_MAX))
            gap_q <= gap_q + 4'h1;
         open_q <= open_d;
         owe_q <= owe_d;
         cke_q <= rst_n_q && cke_d;
         cs_n_q <= cs_n_d;
         rcw_q <= rcw_d;
         addr_q <= addr_d;
         ba_q <= ba_d;
         if (slot)
            odt_q <= odt_i && (st_q == DRSR_ST_RUN) && !go_sr && d_done;
         // The device takes its reset at one rising ck; the release then comes with ck falling.
         rst_n_q <= rst_n_q || ck_q;
         ref_iss_q <= ref_now;
      end
   end

   drsr_timer u_wait (
      .clk_i(sys_clk_i),
      .rst_i(sys_rst_i),
      .load_i(w_load),
      .count_i(w_cnt),
      .done_o(w_done)
   );

   drsr_timer u_refi (
      .clk_i(sys_clk_i),
      .rst_i(sys_rst_i),
      .load_i(tick),
      .count_i(REFI_C),
      .done_o(tick)
   );

   drsr_timer u_dll (
      .clk_i(sys_clk_i),
      .rst_i(sys_rst_i),
      .load_i(d_load),
      .count_i(XSDLL_C),
      .done_o(d_done)
   );

   assign link.ck = ck_q;
   assign link.cke = cke_q;
   assign link.cs_n = cs_n_q;
   assign link.ras_n = rcw_q[2];
   assign link.cas_n = rcw_q[1];
   assign link.we_n = rcw_q[0];
   assign link.addr = addr_q;
   assign link.ba = ba_q;
   assign link.odt = odt_q;
   assign link.reset_n = rst_n_q;
   assign sr_active_o = in_sr;
   assign ref_issued_o = ref_iss_q;
   assign ref_debt_o = debt_q;
endmodule

// File: inc/drsr_cfg.svh
// Timing constants and bus encodings for the refresh and self-refresh link.
// Function
// - Device decodes refresh, starts internal refresh
// - Controller precharges all banks before refresh
// - Refresh row comes from internal counter
// - Refresh completes with all banks idle
// - Only NOP until refresh cycle time passes
// - Controller issues refreshes at average interval
// - At most eight refreshes postponed
// - At most eight refreshes pulled in
// - No refresh debt at self-refresh entry; checked before the termination wait, so a tick during it leaves one owed
// - Device decodes self-refresh entry with CKE low
// - Self-refresh entry only with banks precharged
// - Termination off before self-refresh entry
// - CKE held low during self-refresh
// - DLL off on entry, reset on exit
// - Inputs ignored; refresh within minimum CKE pulse
// - Self-refresh timer runs without link clock
// - Stay in self-refresh minimum CKE pulse
// - Clock stop after hold, stable before exit
// - Exit by CKE high, then exit delays
// - NOP, CKE high, termination off during exit
// - Extra refresh after exit before re-entry
`ifndef DRSR_CFG_SVH
`define DRSR_CFG_SVH
`define DRSR_SYS_NS 50
`define DRSR_CYC_UP(ns) (((ns) + `DRSR_SYS_NS - 1) / `DRSR_SYS_NS)
`define DRSR_CYC_DN(ns) ((ns) / `DRSR_SYS_NS)
`define DRSR_CK_DIV 2
`define DRSR_AVG_REFRESH_INTERVAL_NS 7800
`define DRSR_REFRESH_CYCLE_TIME_NS 110
`define DRSR_PRECHARGE_TIME_NS 14
`define DRSR_SR_EXIT_DELAY_NS 120
`define DRSR_CKE_MIN_PULSE_NS 15
`define DRSR_CLOCK_HOLD_AFTER_SR_ENTRY_NS 10
`define DRSR_CLOCK_STABLE_BEFORE_SR_EXIT_NS 10
`define DRSR_SR_EXIT_DLL_DELAY_TCK 512
`define DRSR_TERMINATION_LATENCY_TCK 6
`define DRSR_REFI_CYC `DRSR_CYC_DN(`DRSR_AVG_REFRESH_INTERVAL_NS)
`define DRSR_RFC_CYC `DRSR_CYC_UP(`DRSR_REFRESH_CYCLE_TIME_NS)
`define DRSR_RP_CYC `DRSR_CYC_UP(`DRSR_PRECHARGE_TIME_NS)
`define DRSR_XS_CYC `DRSR_CYC_UP(`DRSR_SR_EXIT_DELAY_NS)
`define DRSR_CKE_CYC `DRSR_CYC_UP(`DRSR_CKE_MIN_PULSE_NS)
`define DRSR_CKSRE_CYC `DRSR_CYC_UP(`DRSR_CLOCK_HOLD_AFTER_SR_ENTRY_NS)
`define DRSR_CKSRX_CYC `DRSR_CYC_UP(`DRSR_CLOCK_STABLE_BEFORE_SR_EXIT_NS)
`define DRSR_SR_MIN_CYC ((`DRSR_CKE_CYC > `DRSR_CKSRE_CYC) ? `DRSR_CKE_CYC : `DRSR_CKSRE_CYC)
`define DRSR_XSDLL_CYC (`DRSR_SR_EXIT_DLL_DELAY_TCK * `DRSR_CK_DIV)
`define DRSR_TERMINATION_LATENCY_CYC ((`DRSR_TERMINATION_LATENCY_TCK + 1) * `DRSR_CK_DIV)
`define DRSR_DEBT_MAX 5'sh08
`define DRSR_DEBT_MIN (-5'sh08)
`define DRSR_GAP_MAX 4'h8
`define DRSR_A10_ALL 10
`define DRSR_ENC_NOP 3'h7
`define DRSR_ENC_ACT 3'h3
`define DRSR_ENC_RD 3'h5
`define DRSR_ENC_WR 3'h4
`define DRSR_ENC_PRE 3'h2
`define DRSR_ENC_REF 3'h1
`define DRSR_TMR_W 12
`define DRSR_ROW_W 13
`endif

// File: inc/drsr_pkg.sv
// Types and helpers shared by both ends of the refresh link.
`include "drsr_cfg.svh"
package drsr_pkg;
   typedef logic [`DRSR_TMR_W-1:0] drsr_cnt_t;
   typedef enum logic [1:0] {DRSR_U_ACT, DRSR_U_RD, DRSR_U_WR, DRSR_U_PRE} drsr_ucmd_t;
   typedef enum {DRSR_ST_RUN, DRSR_ST_PRE, DRSR_ST_REF, DRSR_ST_ODT, DRSR_ST_SR_MIN,
      DRSR_ST_SR, DRSR_ST_CKON, DRSR_ST_XS} drsr_cst_t;

   // Compares the sampled RAS/CAS/WE triple against a command encoding.
   function automatic logic drsr_is(input logic [2:0] rcw, input logic [2:0] enc);
      drsr_is = (rcw == enc);
   endfunction
endpackage

// File: inc/drsr_if.sv
// Command link between memory controller and memory device.
`timescale 1ns/100ps
interface drsr_if;
   logic ck;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [13:0] addr;
   logic [2:0] ba;
   logic odt;
   logic reset_n;
   modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, addr, ba, odt, reset_n);
   modport dev (input ck, cke, cs_n, ras_n, cas_n, we_n, addr, ba, odt, reset_n);
endinterface

// File: hw/drsr_timer.sv
// Loadable down counter that reports when it has run out.
`timescale 1ns/100ps
module drsr_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire drsr_pkg::drsr_cnt_t count_i,
   output logic done_o
);
   import drsr_pkg::*;
   drsr_cnt_t cnt_q;

   assign done_o = (cnt_q == '0);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cnt_q <= '0;
      else if (load_i)
         cnt_q <= count_i;
      else if (!done_o)
         cnt_q <= cnt_q - 1'b1;
   end
endmodule

// File: hw/drsr_dev.sv
// Memory device end: command decode on the link clock, refresh engine on its oscillator.
`timescale 1ns/100ps
`include "drsr_cfg.svh"
module drsr_dev (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   drsr_if.dev link,
   input wire logic mr1_dll_disable_i,
   output logic self_refresh_o,
   output logic banks_idle_o,
   output logic dll_on_o,
   output logic dll_reset_o,
   output logic refreshing_o,
   output logic [`DRSR_ROW_W-1:0] refresh_row_o
);
   import drsr_pkg::*;
   localparam drsr_cnt_t RFC_C = drsr_cnt_t'(`DRSR_RFC_CYC - 1);
   localparam drsr_cnt_t REFI_C = drsr_cnt_t'(`DRSR_REFI_CYC - 1);

   // Link clock domain. Pins are sampled at the rising edge that the controller aims at.
   logic ck_rst;
   logic [2:0] rcw;
   logic sel;
   logic ref_dec;
   logic sre_dec;
   logic srx_dec;
   logic act_dec;
   logic pre_dec;
   logic cke_prev_q;
   logic sr_q;
   logic ref_tgl_q;
   logic open_q;
   logic dll_on_q;
   logic dll_rst_q;

   assign ck_rst = !link.reset_n;
   assign rcw = {link.ras_n, link.cas_n, link.we_n};
   assign sel = !link.cs_n && cke_prev_q && !sr_q;
   assign ref_dec = sel && link.cke && drsr_is(rcw, `DRSR_ENC_REF);
   assign sre_dec = sel && !link.cke && drsr_is(rcw, `DRSR_ENC_REF);
   assign srx_dec = sr_q && link.cke;
   assign act_dec = sel && link.cke && drsr_is(rcw, `DRSR_ENC_ACT);
   assign pre_dec = sel && link.cke && drsr_is(rcw, `DRSR_ENC_PRE);

   always_ff @(posedge link.ck)
   begin
      if (ck_rst)
      begin
         cke_prev_q <= 1'b0;
         sr_q <= 1'b0;
         ref_tgl_q <= 1'b0;
         open_q <= 1'b0;
         dll_on_q <= 1'b0;
         dll_rst_q <= 1'b0;
      end
      else
      begin
         cke_prev_q <= link.cke;
         sr_q <= (sr_q && !srx_dec) || sre_dec;
         ref_tgl_q <= ref_tgl_q ^ ref_dec;
         open_q <= (open_q || act_dec) && !pre_dec && !ref_dec;
         dll_on_q <= !mr1_dll_disable_i && !sr_q && !sre_dec;
         dll_rst_q <= srx_dec && !mr1_dll_disable_i;
      end
   end

   assign self_refresh_o = sr_q;
   assign banks_idle_o = !open_q;
   assign dll_on_o = dll_on_q;
   assign dll_reset_o = dll_rst_q;

   // Oscillator domain. It keeps refreshing while the link clock stands still.
   logic [1:0] tgl_sync_q;
   logic tgl_prev_q;
   logic [1:0] sr_sync_q;
   logic sr_prev_q;
   logic busy_q;
   logic [`DRSR_ROW_W-1:0] row_q;
   logic rfc_done;
   logic sri_done;
   logic ref_ev;
   logic sr_rise;
   logic sr_tick;
   logic start;

   assign ref_ev = tgl_sync_q[1] ^ tgl_prev_q;
   assign sr_rise = sr_sync_q[1] && !sr_prev_q;
   assign sr_tick = sr_sync_q[1] && sr_prev_q && sri_done;
   assign start = ref_ev || sr_rise || sr_tick;

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         tgl_sync_q <= 2'h0;
         tgl_prev_q <= 1'b0;
         sr_sync_q <= 2'h0;
         sr_prev_q <= 1'b0;
         busy_q <= 1'b0;
         row_q <= '0;
      end
      else
      begin
         tgl_sync_q <= {tgl_sync_q[0], ref_tgl_q};
         tgl_prev_q <= tgl_sync_q[1];
         sr_sync_q <= {sr_sync_q[0], sr_q};
         sr_prev_q <= sr_sync_q[1];
         busy_q <= start || (busy_q && !rfc_done);
         if (start)
            row_q <= row_q + 1'b1;
      end
   end

   drsr_timer u_rfc (
      .clk_i(sys_clk_i),
      .rst_i(sys_rst_i),
      .load_i(start),
      .count_i(RFC_C),
      .done_o(rfc_done)
   );

   drsr_timer u_sri (
      .clk_i(sys_clk_i),
      .rst_i(sys_rst_i),
      .load_i(start),
      .count_i(REFI_C),
      .done_o(sri_done)
   );

   assign refreshing_o = busy_q;
   assign refresh_row_o = row_q;
endmodule

// File: tb/drsr_monitor.sv
// Checker for the controller's command timing on the refresh link.
`timescale 1ns/100ps
`include "drsr_cfg.svh"
module drsr_monitor (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic ck,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [13:0] addr,
   input wire logic [2:0] ba,
   input wire logic odt,
   input wire logic reset_n
);
   logic ck_q;
   logic open_q;
   logic in_sr_q;
   logic owe_q;
   logic [10:0] xs_q;
   logic [4:0] odt_q;
   wire [2:0] rcw_w = {ras_n, cas_n, we_n};
   wire cmd_w = !cs_n && rcw_w != `DRSR_ENC_NOP;
   wire ref_w = cmd_w && rcw_w == `DRSR_ENC_REF;
   wire pre_all_w = cmd_w && rcw_w == `DRSR_ENC_PRE && addr[`DRSR_A10_ALL];
   wire dll_cmd_w = cmd_w && (rcw_w == `DRSR_ENC_RD || rcw_w == `DRSR_ENC_WR);
   wire ck_run_w = ck != ck_q;
   wire exit_w = in_sr_q && cke;

   // Tracks open rows, self-refresh residence, the owed refresh and the exit window.
   always_ff @(posedge sys_clk_i)
   begin
      ck_q <= ck;
      if (sys_rst_i || !reset_n)
      begin
         open_q <= 1'b0;
         in_sr_q <= 1'b0;
         owe_q <= 1'b0;
         xs_q <= 11'h000;
         odt_q <= 5'h00;
      end
      else
      begin
         open_q <= (open_q || (cmd_w && rcw_w == `DRSR_ENC_ACT)) && !pre_all_w;
         in_sr_q <= $fell(cke) || (in_sr_q && !cke);
         owe_q <= exit_w || (owe_q && !(ref_w && cke));
         xs_q <= exit_w ? 11'h001 :
            ((xs_q != 11'h000 && xs_q != 11'h3FF) ? xs_q + 11'h001 : 11'h000);
         odt_q <= odt ? 5'h00 : odt_q + {4'h0, odt_q != 5'h1F};
      end
   end

   default clocking mon_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   ref_gap_a: assert property ($rose(ref_w && cke) |=> ref_w ##1 (!cmd_w) [*3])
      else $error("command inside refresh cycle time");
   ref_idle_a: assert property (ref_w && cke |-> !open_q)
      else $error("refresh with a row open");
   sre_idle_a: assert property ($fell(cke) |-> ref_w && !open_q)
      else $error("bad self-refresh entry");
   sre_odt_a: assert property ($fell(cke) |-> !odt && odt_q >= `DRSR_TERMINATION_LATENCY_CYC)
      else $error("termination not off before entry");
   ck_hold_a: assert property ($fell(cke) |=> ck_run_w)
      else $error("clock stopped too early");
   ck_restart_a: assert property ($rose(cke) && in_sr_q |-> $past(ck_run_w))
      else $error("clock not running before exit");
   xs_nop_a: assert property ($rose(cke) && in_sr_q |-> (!cmd_w) [*4])
      else $error("command inside exit delay");
   dll_wait_a: assert property (xs_q != 11'h000 |-> cke && !odt && !dll_cmd_w)
      else $error("bad link state in dll exit delay");
   sr_reentry_a: assert property ($fell(cke) |-> !owe_q)
      else $error("re-entry without extra refresh");

   cover property ($rose(ref_w && cke));
   cover property ($fell(cke));
   cover property ($rose(cke) && in_sr_q);
endmodule

// File: tb/tb_dram_refresh_self_refresh.sv
// Self-checking bench with controller and device joined back to back.
`timescale 1ns/100ps
`include "drsr_cfg.svh"
module tb_dram_refresh_self_refresh;
   import drsr_pkg::*;
   logic sys_clk_i = 1'b0;
   logic osc_clk = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   drsr_ucmd_t cmd_i = DRSR_U_ACT;
   logic [13:0] cmd_addr_i = 14'h0000;
   logic [2:0] cmd_bank_i = 3'h0;
   logic odt_i = 1'b0;
   logic sr_req_i = 1'b0;
   logic mr1_dll_disable_i = 1'b0;
   logic cmd_ready_o, sr_active_o, ref_issued_o, self_refresh_o, banks_idle_o;
   logic dll_on_o, dll_reset_o, refreshing_o;
   logic signed [4:0] ref_debt_o;
   logic [`DRSR_ROW_W-1:0] refresh_row_o;
   int n_errors = 0;
   int n_compared = 0;
   drsr_if link_if ();

   drsr_ctrl i_drsr_ctrl (.sys_clk_i, .sys_rst_i, .link(link_if.ctrl), .cmd_valid_i, .cmd_i,
      .cmd_addr_i, .cmd_bank_i, .cmd_ready_o, .odt_i, .sr_req_i, .sr_active_o, .ref_issued_o,
      .ref_debt_o);
   drsr_dev i_drsr_dev (.sys_clk_i(osc_clk), .sys_rst_i, .link(link_if.dev), .mr1_dll_disable_i,
      .self_refresh_o, .banks_idle_o, .dll_on_o, .dll_reset_o, .refreshing_o, .refresh_row_o);
   drsr_monitor i_drsr_monitor (.sys_clk_i, .sys_rst_i, .ck(link_if.ck), .cke(link_if.cke),
      .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n),
      .addr(link_if.addr), .ba(link_if.ba), .odt(link_if.odt), .reset_n(link_if.reset_n));

   initial
   begin
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   // The device oscillator runs near the system rate but drifts in phase.
   initial
   begin
      #7;
      forever #24.7 osc_clk = ~osc_clk;
   end

   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input bit ok, input string msg);
      n_compared++;
      if (!ok)
      begin
         n_errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic bound(input int n, input int lim);
      if (n >= lim)
      begin
         check(1'b0, "wait ran out");
         give_verdict();
      end
   endtask

   task automatic send(input drsr_ucmd_t c, input logic [13:0] a, input logic [2:0] b);
      int n;
      @(posedge sys_clk_i);
      cmd_i <= c;
      cmd_addr_i <= a;
      cmd_bank_i <= b;
      cmd_valid_i <= 1'b1;
      @(negedge sys_clk_i);
      for (n = 0; n < 4000 && cmd_ready_o !== 1'b1; n++)
         @(negedge sys_clk_i);
      bound(n, 4000);
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b0;
   endtask

   task automatic t_pull_in();
      int n;
      int refs = 0;
      logic [`DRSR_ROW_W-1:0] row0;
      row0 = refresh_row_o;
      for (n = 0; n < 150; n++)
      begin
         @(negedge sys_clk_i);
         refs += ref_issued_o === 1'b1;
      end
      check(refs == 9 && refresh_row_o - row0 == refs, "pull-in count");
      check(ref_debt_o === 5'sh18 && banks_idle_o === 1'b1, "floor");
   endtask

   task automatic t_busy();
      int n;
      int gap = 0;
      int worst = 0;
      int refs = 0;
      bit in_range = 1'b1;
      @(posedge sys_clk_i);
      odt_i <= 1'b1;
      send(DRSR_U_ACT, 14'h0123, 3'h1);
      repeat (2) @(negedge sys_clk_i);
      check(banks_idle_o === 1'b0, "row not open after activate");
      @(posedge sys_clk_i);
      cmd_i <= DRSR_U_RD;
      cmd_valid_i <= 1'b1;
      for (n = 0; n < 3000; n++)
      begin
         @(negedge sys_clk_i);
         gap = ref_issued_o === 1'b1 ? 0 : gap + 1;
         worst = gap > worst ? gap : worst;
         refs += ref_issued_o === 1'b1;
         in_range &= ref_debt_o >= 5'sh18 && ref_debt_o <= 5'sh08;
      end
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b0;
      send(DRSR_U_PRE, 14'h0400, 3'h0);
      check(refs > 0 && worst <= 9 * `DRSR_REFI_CYC, "gap under load");
      check(in_range, "debt range");
      check(banks_idle_o === 1'b1, "banks open after forced refresh");
   endtask

   task automatic t_self_refresh(input logic dll_dis);
      int n;
      bit seen = 1'b0;
      bit stopped = 1'b1;
      logic [`DRSR_ROW_W-1:0] row0;
      time t0;
      @(posedge sys_clk_i);
      mr1_dll_disable_i <= dll_dis;
      sr_req_i <= 1'b1;
      for (n = 0; n < 2000 && self_refresh_o !== 1'b1; n++)
         @(negedge sys_clk_i);
      bound(n, 2000);
      check(sr_active_o === 1'b1 && ref_debt_o <= 5'sh00, "debt at entry");
      check(dll_on_o === 1'b0, "dll on in self-refresh");
      for (n = 0; n < 10 && !seen; n++)
      begin
         @(negedge sys_clk_i);
         seen = refreshing_o === 1'b1;
      end
      check(seen, "no refresh after entry");
      row0 = refresh_row_o;
      for (n = 0; n < 340; n++)
      begin
         @(negedge sys_clk_i);
         stopped &= n < 10 || link_if.ck === 1'b0;
      end
      check(stopped && refresh_row_o - row0 >= 2, "timer refresh");
      @(posedge sys_clk_i);
      sr_req_i <= 1'b0;
      for (n = 0; n < 200 && sr_active_o !== 1'b0; n++)
         @(negedge sys_clk_i);
      bound(n, 200);
      t0 = $time;
      seen = 1'b0;
      for (n = 0; n < 40; n++)
      begin
         @(negedge sys_clk_i);
         seen |= dll_reset_o === 1'b1;
      end
      check(dll_on_o === !dll_dis && seen === !dll_dis, "dll at exit");
      send(DRSR_U_RD, 14'h0000, 3'h0);
      check(($time - t0 + 25) / 50 >= `DRSR_XSDLL_CYC, "read too early");
   endtask

   initial
   begin
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      t_pull_in();
      $display("test pull_in done");
      t_busy();
      $display("test busy done");
      t_self_refresh(1'b0);
      $display("test self_refresh dll on done");
      t_self_refresh(1'b1);
      $display("test self_refresh dll off done");
      give_verdict();
   end
endmodule
